// >>> design/pmc_macrocell_top.sv
`include "pmc_regs.svh"
`default_nettype none
module pmc_macrocell_top
	import pmc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        config_region_select,
	input  wire logic [7:0]  host_addr,
	input  wire logic [15:0] host_wdata,
	input  wire logic        write_strobe_low_n,
	input  wire logic        read_strobe_n,
	input  wire logic        address_strobe,
	output logic      [15:0] host_rdata,
	output logic             host_rdata_oe_n,
	input  wire logic [15:0] cell_sum_pt,
	input  wire logic [15:0] cell_clk_pt,
	input  wire logic [15:0] cell_clk_sel_ext,
	input  wire logic [15:0] cell_preset_pt,
	input  wire logic [15:0] cell_clear_pt,
	input  wire logic        macrocell_clock_input,
	input  wire logic [63:0] cell_pt_need,
	output logic      [47:0] cell_borrowed,
	output logic      [15:0] cell_expanded,
	output logic      [15:0] cell_feedback,
	input  wire logic [15:0] cell_oe_pt,
	input  wire logic [15:0] port_dir,
	input  wire logic [15:0] cell_is_output,
	input  wire logic [15:0] cell_has_oe_eq,
	input  wire logic        slave_read_pt,
	input  wire logic [7:0]  port_a_data_out,
	output logic      [15:0] port_ab_out,
	output logic      [15:0] port_ab_oe_n,
	input  wire logic [23:0] port_abc_in,
	input  wire logic [47:0] input_cell_mode,
	input  wire logic [5:0]  input_nibble_sel_strobe,
	input  wire logic [5:0]  input_nibble_pt,
	output logic      [23:0] logic_input_bus,
	input  wire logic [7:0]  ecs_pt,
	input  wire logic [7:0]  ecs_active_low,
	input  wire logic [7:0]  ecs_oe_pt,
	input  wire logic [7:0]  ecs_dir,
	output logic      [7:0]  external_select_outputs,
	output logic      [7:0]  external_select_oe_n
);
	pmc_alloc_if alloc_bus ();  // allocator demand and results

	pmc_wr_state_type wr_state;      // host write tracker
	pmc_wr_state_type next_wr_state;
	logic [15:0] wr_hold_data;       // data seen while strobe was low
	logic [15:0] next_wr_hold_data;
	logic [7:0]  mask_a;             // port a cell write mask
	logic [7:0]  next_mask_a;
	logic [7:0]  mask_b;             // port b cell write mask
	logic [7:0]  next_mask_b;
	logic [7:0]  wr_addr;            // offset of the pending write
	logic [7:0]  next_wr_addr;
	logic        host_load;          // pulse: cell load commits now
	logic [15:0] mask16;             // both masks side by side

	logic [15:0] cell_q;             // output cell flip-flops
	logic [15:0] next_cell_q;
	logic [15:0] clk_pt_prev;        // edge history of term clocks
	logic        mclk_prev;          // edge history of external clock
	logic [15:0] sum_delayed;        // expansion stage of sums
	logic [15:0] clk_edge;           // rising edge of selected clock
	logic [15:0] cell_event;         // any own flop input active

	logic [15:0] next_port_ab_out;
	logic [15:0] next_port_ab_oe_n;
	logic [7:0]  next_ecs_out;
	logic [7:0]  next_ecs_oe_n;
	logic [15:0] next_host_rdata;
	logic        rd_hit;             // read of a mapped location

	////////////////////////////////////////////////////////////////////////
	// allocator and input cells
	assign alloc_bus.need = cell_pt_need;

	pmc_pt_alloc u_alloc
	(
		.bus (alloc_bus)
	);

	assign cell_borrowed = alloc_bus.borrowed;
	assign cell_expanded = alloc_bus.expanded;

	pmc_input_cells u_incells
	(
		.core_clk          (core_clk),
		.rst_n             (rst_n),
		.address_strobe    (address_strobe),
		.pin_in            (port_abc_in),
		.cell_mode         (input_cell_mode),
		.nibble_sel_strobe (input_nibble_sel_strobe),
		.nibble_pt         (input_nibble_pt),
		.cell_out          (logic_input_bus)
	);

	////////////////////////////////////////////////////////////////////////
	// host write: hold data while strobe low, commit on its rise
	always_comb
	begin
		next_wr_state = wr_state;
		next_wr_hold_data = wr_hold_data;
		next_wr_addr = wr_addr;
		next_mask_a = mask_a;
		next_mask_b = mask_b;
		host_load = 1'b0;
		case (wr_state)
			PMC_WR_IDLE:
			begin
				// only accesses inside the configuration region count
				if (config_region_select && !write_strobe_low_n)
				begin
					next_wr_state = PMC_WR_ACTIVE;
					next_wr_hold_data = host_wdata;
					next_wr_addr = host_addr;
				end
			end
			PMC_WR_ACTIVE:
			begin
				if (!write_strobe_low_n)
				begin
					// data may settle late in the strobe, keep the last
					next_wr_hold_data = host_wdata;
				end
				else
				begin
					// trailing edge: data lands now
					next_wr_state = PMC_WR_IDLE;
					host_load = (wr_addr == `PMC_OFS_OUT_CELLS);
					if (wr_addr == `PMC_OFS_MASK_A)
						next_mask_a = wr_hold_data[7:0];
					if (wr_addr == `PMC_OFS_MASK_B)
						next_mask_b = wr_hold_data[7:0];
				end
			end
			default: next_wr_state = PMC_WR_IDLE;
		endcase
	end

	// write tracker and masks; masks clear to loading enabled
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wr_state <= PMC_WR_IDLE;
			wr_hold_data <= 16'h0000;
			wr_addr <= 8'h00;
			mask_a <= `PMC_MASK_RESET;
			mask_b <= `PMC_MASK_RESET;
		end
		else
		begin
			wr_state <= next_wr_state;
			wr_hold_data <= next_wr_hold_data;
			wr_addr <= next_wr_addr;
			mask_a <= next_mask_a;
			mask_b <= next_mask_b;
		end
	end

	assign mask16 = {mask_b, mask_a};

	////////////////////////////////////////////////////////////////////////
	// output cell flops: host load, preset, clear, then clock
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			clk_edge[i] = cell_clk_sel_ext[i] ? (macrocell_clock_input && !mclk_prev)
				: (cell_clk_pt[i] && !clk_pt_prev[i]);
		cell_event = clk_edge | cell_preset_pt | cell_clear_pt;
		for (int i = 0; i < 16; i++)
		begin
			next_cell_q[i] = cell_q[i];
			if (host_load && !mask16[i])
				next_cell_q[i] = wr_hold_data[i];
			else if (cell_preset_pt[i])
				next_cell_q[i] = 1'b1;
			else if (cell_clear_pt[i])
				next_cell_q[i] = 1'b0;
			else if (clk_edge[i])
				// spilled equations pass one more stage first
				next_cell_q[i] = alloc_bus.expanded[i] ? sum_delayed[i]
					: cell_sum_pt[i];
		end
	end

	// cell flops and clock edge history
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cell_q <= 16'h0000;
			clk_pt_prev <= 16'h0000;
			mclk_prev <= 1'b0;
			sum_delayed <= 16'h0000;
		end
		else
		begin
			cell_q <= next_cell_q;
			clk_pt_prev <= cell_clk_pt;
			mclk_prev <= macrocell_clock_input;
			sum_delayed <= cell_sum_pt;
		end
	end

	// internal nodes still reach the array whether or not pinned
	assign cell_feedback = cell_q;

	////////////////////////////////////////////////////////////////////////
	// pins and chip selects; enables are active low at the ports
	always_comb
	begin
		next_port_ab_out = cell_q;
		// mailbox: slave reads the master's port a data register
		if (slave_read_pt)
			next_port_ab_out[7:0] = port_a_data_out;
		for (int i = 0; i < 16; i++)
			next_port_ab_oe_n[i] = !(cell_is_output[i] && ((!cell_has_oe_eq[i])
				|| cell_oe_pt[i] || port_dir[i]));
		if (slave_read_pt)
			next_port_ab_oe_n[7:0] = 8'h00;
		next_ecs_out = ecs_pt ^ ecs_active_low;
		next_ecs_oe_n = ~(ecs_oe_pt | ecs_dir);
	end

	// output drivers; reset turns every enable off, undeclared ones drive from the first edge after
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			port_ab_out <= 16'h0000;
			port_ab_oe_n <= 16'hffff;
			external_select_outputs <= 8'h00;
			external_select_oe_n <= 8'hff;
		end
		else
		begin
			port_ab_out <= next_port_ab_out;
			port_ab_oe_n <= next_port_ab_oe_n;
			external_select_outputs <= next_ecs_out;
			external_select_oe_n <= next_ecs_oe_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host read; unmapped offsets leave the bus undriven
	always_comb
	begin
		rd_hit = 1'b1;
		next_host_rdata = 16'h0000;
		case (host_addr)
			`PMC_OFS_OUT_CELLS: next_host_rdata = cell_q;
			`PMC_OFS_IN_AB:     next_host_rdata = logic_input_bus[15:0];
			`PMC_OFS_IN_C:      next_host_rdata = {8'h00, logic_input_bus[23:16]};
			`PMC_OFS_MASK_A:    next_host_rdata = {8'h00, mask_a};
			`PMC_OFS_MASK_B:    next_host_rdata = {8'h00, mask_b};
			default:            rd_hit = 1'b0;
		endcase
	end

	// read data held one cycle after sampling the strobe
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			host_rdata <= 16'h0000;
		else if (config_region_select && !read_strobe_n)
			host_rdata <= next_host_rdata;
	end

	assign host_rdata_oe_n = !(config_region_select && !read_strobe_n && rd_hit);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_cell_wr_low;
		config_region_select && !write_strobe_low_n && host_addr == `PMC_OFS_OUT_CELLS
			&& wr_state == PMC_WR_IDLE;
	endsequence

	sequence s_cell_read;
		config_region_select && !read_strobe_n && host_addr == `PMC_OFS_OUT_CELLS;
	endsequence

	chk_mask_after_reset: assert property ($rose(rst_n) |-> mask16 == 16'h0000)
		else $error("write masks not clear after reset");
	chk_load_on_release: assert property
		(s_cell_wr_low ##1 write_strobe_low_n |-> host_load)
		else $error("cell load missed strobe release");
	chk_load_overrides: assert property
		(host_load |=> ((cell_q ^ $past(wr_hold_data)) & ~$past(mask16)) == 16'h0000)
		else $error("unmasked cell not loaded");
	chk_mask_blocks: assert property
		(host_load |-> ((next_cell_q ^ cell_q) & mask16 & ~cell_event) == 16'h0000)
		else $error("masked cell changed by host write");
	chk_preset_high: assert property
		(!host_load |=> (cell_q & $past(cell_preset_pt)) == $past(cell_preset_pt))
		else $error("preset did not set cell");
	chk_cells_idle: assert property
		(!host_load && cell_event == 16'h0000 |=> $stable(cell_q))
		else $error("cell changed without an edge");
	chk_pin_enable: assert property
		(1'b1 |=> ((~port_ab_oe_n) & $past(cell_is_output) & $past(port_dir))
			== ($past(cell_is_output) & $past(port_dir)))
		else $error("direction bit did not enable pin");
	chk_ecs_polarity: assert property
		(1'b1 |=> external_select_outputs == ($past(ecs_pt) ^ $past(ecs_active_low)))
		else $error("chip select polarity wrong");
	chk_ecs_enable: assert property
		(1'b1 |=> external_select_oe_n == ~($past(ecs_oe_pt) | $past(ecs_dir)))
		else $error("chip select enable wrong");
	chk_read_cells: assert property (s_cell_read |=> host_rdata == $past(cell_q))
		else $error("cell readback wrong");
endmodule : pmc_macrocell_top
`default_nettype wire

// >>> design/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// offsets inside the configuration region
`define PMC_OFS_IN_AB      8'h10
`define PMC_OFS_IN_C       8'h12
`define PMC_OFS_OUT_CELLS  8'h20
`define PMC_OFS_MASK_A     8'h22
`define PMC_OFS_MASK_B     8'h24
// reset values
`define PMC_MASK_RESET     8'h00
// product-term budget per cell
`define PMC_NATIVE_A       4'h3
`define PMC_NATIVE_B       4'h4
`define PMC_BORROW_A       4'h6
`define PMC_BORROW_B_LO    4'h5
`define PMC_BORROW_B_HI    4'h6
// data bus lanes of the two cell groups
`define PMC_GROUP_A_LSB    0
`define PMC_GROUP_B_LSB    8
`endif

// >>> design/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
	// input cell operating mode
	typedef enum logic [1:0]
	{
		PMC_INCELL_PASS  = 2'b00,
		PMC_INCELL_LATCH = 2'b01,
		PMC_INCELL_REG   = 2'b10
	} pmc_incell_mode_type;

	// host write tracker
	typedef enum logic [0:0]
	{
		PMC_WR_IDLE   = 1'b0,
		PMC_WR_ACTIVE = 1'b1
	} pmc_wr_state_type;
endpackage : pmc_pkg
`default_nettype wire

// >>> design/pmc_alloc_if.sv
`default_nettype none
// allocator demand and results between core and allocator
interface pmc_alloc_if;
	logic [15:0][3:0] need;      // terms each equation wants
	logic [15:0][2:0] borrowed;  // terms granted from the pool
	logic [15:0]      expanded;  // equation spills into other cells

	modport alloc (input need, output borrowed, expanded);
	modport core  (output need, input borrowed, expanded);
endinterface : pmc_alloc_if
`default_nettype wire

// >>> design/pmc_pt_alloc.sv
`include "pmc_regs.svh"
`default_nettype none
module pmc_pt_alloc
	import pmc_pkg::*;
(
	pmc_alloc_if.alloc bus
);
	////////////////////////////////////////////////////////////////////////
	// greedy allocation in cell order; a granted term leaves the pool
	always_comb
	begin
		logic [6:0] pool;    // unused native terms left to lend
		logic [3:0] nat;     // native terms of this cell
		logic [3:0] lim;     // borrow limit of this cell
		logic [3:0] want;    // terms beyond the native ones
		logic [3:0] grant;   // terms actually borrowed
		pool = 7'h00;
		nat = 4'h0;
		lim = 4'h0;
		want = 4'h0;
		grant = 4'h0;
		bus.borrowed = '0;
		bus.expanded = '0;
		// pool is what the cells leave unused of their own terms
		for (int i = 0; i < 16; i++)
		begin
			nat = (i < 8) ? `PMC_NATIVE_A : `PMC_NATIVE_B;
			if (bus.need[i] < nat)
				pool = pool + {3'h0, nat - bus.need[i]};
		end
		for (int i = 0; i < 16; i++)
		begin
			nat = (i < 8) ? `PMC_NATIVE_A : `PMC_NATIVE_B;
			lim = (i < 8) ? `PMC_BORROW_A :
				((i < 12) ? `PMC_BORROW_B_LO : `PMC_BORROW_B_HI);
			want = (bus.need[i] > nat) ? bus.need[i] - nat : 4'h0;
			grant = (want < lim) ? want : lim;
			if ({3'h0, grant} > pool)
				grant = pool[3:0];
			// a term once granted is gone for every other cell
			pool = pool - {3'h0, grant};
			bus.borrowed[i] = grant[2:0];
			// shortfall is made up by spending further cells
			bus.expanded[i] = (want > grant);
		end
	end
endmodule : pmc_pt_alloc
`default_nettype wire

// >>> design/pmc_input_cells.sv
`default_nettype none
module pmc_input_cells
	import pmc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        address_strobe,
	input  wire logic [23:0] pin_in,
	input  wire logic [47:0] cell_mode,
	input  wire logic [5:0]  nibble_sel_strobe,
	input  wire logic [5:0]  nibble_pt,
	output logic      [23:0] cell_out
);
	logic [5:0] nib_en;        // selected enable per group of four
	logic [5:0] nib_en_prev;   // last value, for rising edges
	logic [5:0] next_nib_en_prev;

	////////////////////////////////////////////////////////////////////////
	// enable of each nibble: product term or host address strobe
	always_comb
	begin
		for (int n = 0; n < 6; n++)
			nib_en[n] = nibble_sel_strobe[n] ? address_strobe : nibble_pt[n];
		next_nib_en_prev = nib_en;
	end

	// edge history of the nibble enables
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			nib_en_prev <= 6'h00;
		else
			nib_en_prev <= next_nib_en_prev;
	end

	////////////////////////////////////////////////////////////////////////
	// one cell per pin of ports a, b and c
	genvar g;
	generate
		for (g = 0; g < 24; g++)
		begin : g_cell
			pmc_incell_mode_type mode;  // this cell's mode
			logic held;              // latched or registered value
			logic next_held;
			logic en;                // enable of the cell's nibble
			assign mode = pmc_incell_mode_type'(cell_mode[2*g +: 2]);
			assign en = nib_en[g/4];

			// capture: latch follows while open, register on rise
			always_comb
			begin
				next_held = held;
				case (mode)
					PMC_INCELL_LATCH: if (en) next_held = pin_in[g];
					PMC_INCELL_REG:   if (en && !nib_en_prev[g/4]) next_held = pin_in[g];
					default:          next_held = held;
				endcase
			end

			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					held <= 1'b0;
				else
					held <= next_held;
			end

			// an open latch is transparent, pass mode ignores storage
			always_comb
			begin
				case (mode)
					PMC_INCELL_LATCH: cell_out[g] = en ? pin_in[g] : held;
					PMC_INCELL_REG:   cell_out[g] = held;
					default:          cell_out[g] = pin_in[g];
				endcase
			end
		end
	endgenerate
endmodule : pmc_input_cells
`default_nettype wire

// >>> test/pmc_host_model.sv
`default_nettype none
// host microcontroller on the parallel bus, register reads and writes only
module pmc_host_model
	import pmc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic [15:0] host_rdata,
	input  wire logic        host_rdata_oe_n,
	output logic             config_region_select,
	output logic      [7:0]  host_addr,
	output logic      [15:0] host_wdata,
	output logic             write_strobe_low_n,
	output logic             read_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle at time zero, both strobes high
	initial
	begin
		config_region_select = 1'b0;
		host_addr            = 8'h00;
		host_wdata           = 16'h0000;
		write_strobe_low_n   = 1'b1;
		read_strobe_n        = 1'b1;
	end

	// strobe low for n edges; the edge that sees it high again commits
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
		@(posedge core_clk);
		#1;
		config_region_select = 1'b1;
		host_addr            = a;
		host_wdata           = d;
		write_strobe_low_n   = 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
		write_strobe_low_n = 1'b1;
		@(posedge core_clk);
		#1;
		// released lines show inverted values so stale data cannot pass
		config_region_select = 1'b0;
		host_addr            = ~a;
		host_wdata           = ~d;
	endtask : wr

	// one-edge read; enable is combinational, data follows the edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic oe_n);
		@(posedge core_clk);
		#1;
		config_region_select = 1'b1;
		host_addr            = a;
		read_strobe_n        = 1'b0;
		#2;
		oe_n = host_rdata_oe_n;
		@(posedge core_clk);
		#1;
		d                    = host_rdata;
		read_strobe_n        = 1'b1;
		config_region_select = 1'b0;
		host_addr            = ~a;
	endtask : rd
endmodule : pmc_host_model
`default_nettype wire

// >>> test/test_pld_macrocell_host_access.sv
`include "pmc_regs.svh"
`default_nettype none
// self-checking bench for the macrocell fabric and its host path
module test_pld_macrocell_host_access
	import pmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk, rst_n, address_strobe, macrocell_clock_input, slave_read_pt;
	logic        config_region_select, write_strobe_low_n, read_strobe_n, host_rdata_oe_n;
	logic [7:0]  host_addr, port_a_data_out, ecs_pt, ecs_active_low, ecs_oe_pt, ecs_dir;
	logic [7:0]  external_select_outputs, external_select_oe_n;
	logic [15:0] host_wdata, host_rdata, cell_sum_pt, cell_clk_pt, cell_clk_sel_ext;
	logic [15:0] cell_preset_pt, cell_clear_pt, cell_expanded, cell_feedback, cell_oe_pt;
	logic [15:0] port_dir, cell_is_output, cell_has_oe_eq, port_ab_out, port_ab_oe_n;
	logic [23:0] port_abc_in, logic_input_bus;
	logic [47:0] input_cell_mode, cell_borrowed;
	logic [63:0] cell_pt_need;
	logic [5:0]  input_nibble_sel_strobe, input_nibble_pt;
	int          errors;    // mismatches
	int          tests_run; // comparisons
	logic [15:0] rd_d;      // word returned by a host read
	logic        rd_oe_n;   // data enable seen during that read
	logic        seen;      // a short-lived value showed up
	// pin cases: is_output, has_oe_eq, oe_pt, dir, expected enable
	localparam logic [4:0]  pin_cases [5] = '{5'h11, 5'h18, 5'h1d, 5'h1b, 5'h06};
	// select cases: term, active low, oe term, direction
	localparam logic [31:0] ecs_cases [2] = '{32'hcaa6c003, 32'h350f0c00};
	// expected per case: select level, then its active-low enable
	localparam logic [15:0] ecs_exp [2] = '{16'h6c3c, 16'h3af3};

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	pmc_macrocell_top i_pmc_macrocell_top
	(
		.core_clk, .rst_n, .config_region_select, .host_addr, .host_wdata,
		.write_strobe_low_n, .read_strobe_n, .address_strobe, .host_rdata, .host_rdata_oe_n,
		.cell_sum_pt, .cell_clk_pt, .cell_clk_sel_ext, .cell_preset_pt, .cell_clear_pt,
		.macrocell_clock_input, .cell_pt_need, .cell_borrowed, .cell_expanded, .cell_feedback,
		.cell_oe_pt, .port_dir, .cell_is_output, .cell_has_oe_eq, .slave_read_pt,
		.port_a_data_out, .port_ab_out, .port_ab_oe_n, .port_abc_in, .input_cell_mode,
		.input_nibble_sel_strobe, .input_nibble_pt, .logic_input_bus, .ecs_pt,
		.ecs_active_low, .ecs_oe_pt, .ecs_dir, .external_select_outputs, .external_select_oe_n
	);

	pmc_host_model i_pmc_host_model
	(
		.core_clk, .host_rdata, .host_rdata_oe_n, .config_region_select, .host_addr,
		.host_wdata, .write_strobe_low_n, .read_strobe_n
	);

	////////////////////////////////////////////////////////////////////////////////
	// compare, count, report
	task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
		tests_run++;
		if (seen_v !== exp_v)
		begin
			errors++;
			$display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : check

	// step n edges, then land just after the last one
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	// host load, strobe timing, unmapped offsets, masks
	task automatic t_host();
		i_pmc_host_model.rd(`PMC_OFS_MASK_A, rd_d, rd_oe_n);
		check(rd_d[7:0], 8'h00);
		i_pmc_host_model.rd(`PMC_OFS_MASK_B, rd_d, rd_oe_n);
		check(rd_d[7:0], 8'h00);
		i_pmc_host_model.wr(`PMC_OFS_OUT_CELLS, 16'ha55a, 1);
		cyc(2);
		check(cell_feedback, 16'ha55a);
		i_pmc_host_model.rd(`PMC_OFS_OUT_CELLS, rd_d, rd_oe_n);
		check(rd_d, 16'ha55a);
		check(rd_oe_n, 1'b0);
		i_pmc_host_model.rd(8'h30, rd_d, rd_oe_n);
		check(rd_oe_n, 1'b1);
		// long strobe: nothing may land before its trailing edge
		fork
			i_pmc_host_model.wr(`PMC_OFS_OUT_CELLS, 16'h0000, 3);
			begin
				cyc(3);
				check(cell_feedback, 16'ha55a);
			end
		join
		cyc(2);
		check(cell_feedback, 16'h0000);
		i_pmc_host_model.wr(8'h30, 16'hffff, 1);
		cyc(2);
		check(cell_feedback, 16'h0000);
		i_pmc_host_model.wr(`PMC_OFS_MASK_A, 16'h000f, 1);
		i_pmc_host_model.wr(`PMC_OFS_MASK_B, 16'h00f0, 1);
		i_pmc_host_model.rd(`PMC_OFS_MASK_A, rd_d, rd_oe_n);
		check(rd_d[7:0], 8'h0f);
		i_pmc_host_model.rd(`PMC_OFS_MASK_B, rd_d, rd_oe_n);
		check(rd_d[7:0], 8'hf0);
		i_pmc_host_model.wr(`PMC_OFS_OUT_CELLS, 16'hffff, 1);
		cyc(2);
		check(cell_feedback, 16'h0ff0);
		i_pmc_host_model.rd(`PMC_OFS_OUT_CELLS, rd_d, rd_oe_n);
		check(rd_d, 16'h0ff0);
		i_pmc_host_model.wr(`PMC_OFS_MASK_A, 16'h0000, 1);
		i_pmc_host_model.wr(`PMC_OFS_MASK_B, 16'h0000, 1);
		$display("test host access done");
	endtask : t_host

	// preset, clear, load priority, external clock
	task automatic t_cells();
		cell_preset_pt = 16'hffff;
		cyc(2);
		check(cell_feedback, 16'hffff);
		cell_preset_pt = 16'h0000;
		cell_clear_pt  = 16'h00ff;
		cyc(2);
		check(cell_feedback, 16'hff00);
		seen = 1'b0;
		fork
			i_pmc_host_model.wr(`PMC_OFS_OUT_CELLS, 16'h5555, 1);
			repeat (6)
			begin
				cyc(1);
				if (cell_feedback[7:0] === 8'h55)
					seen = 1'b1;
			end
		join
		check(seen, 1'b1);
		check(cell_feedback, 16'h5500);
		cell_clear_pt    = 16'h0000;
		cell_clk_sel_ext = 16'hffff;
		cell_sum_pt      = 16'h3c96;
		cyc(2);
		check(cell_feedback, 16'h5500);
		macrocell_clock_input = 1'b1;
		cyc(3);
		check(cell_feedback, 16'h3c96);
		cell_sum_pt = 16'h0000;
		cyc(3);
		check(cell_feedback, 16'h3c96);
		macrocell_clock_input = 1'b0;
		cell_clk_sel_ext      = 16'h0000;
		$display("test cell flops done");
	endtask : t_cells

	// pin enables, internal nodes, mailbox read
	task automatic t_pins();
		for (int i = 0; i < 5; i++)
		begin
			cell_is_output = {16{pin_cases[i][4]}};
			cell_has_oe_eq = {16{pin_cases[i][3]}};
			cell_oe_pt     = {16{pin_cases[i][2]}};
			port_dir       = {16{pin_cases[i][1]}};
			cyc(3);
			check(port_ab_oe_n, {16{~pin_cases[i][0]}});
			check(cell_feedback, 16'h3c96);
			if (pin_cases[i][0])
				check(port_ab_out, 16'h3c96);
		end
		slave_read_pt   = 1'b1;
		port_a_data_out = 8'h5b;
		cyc(3);
		check(port_ab_out[7:0], 8'h5b);
		check(port_ab_oe_n[7:0], 8'h00);
		slave_read_pt = 1'b0;
		$display("test pins done");
	endtask : t_pins

	// input cells: pass, strobe latch, term register per nibble
	task automatic t_inputs();
		port_abc_in = 24'ha1b2c3;
		cyc(1);
		check(logic_input_bus, 24'ha1b2c3);
		i_pmc_host_model.rd(`PMC_OFS_IN_AB, rd_d, rd_oe_n);
		check(rd_d, 16'hb2c3);
		i_pmc_host_model.rd(`PMC_OFS_IN_C, rd_d, rd_oe_n);
		check(rd_d[7:0], 8'ha1);
		input_cell_mode         = {24{2'b01}};
		input_nibble_sel_strobe = 6'h3f;
		address_strobe          = 1'b1;
		port_abc_in             = 24'h0f0e0d;
		cyc(2);
		check(logic_input_bus, 24'h0f0e0d);
		address_strobe = 1'b0;
		cyc(1);
		port_abc_in = 24'hffffff;
		cyc(2);
		check(logic_input_bus, 24'h0f0e0d);
		input_cell_mode         = {24{2'b10}};
		input_nibble_sel_strobe = 6'h00;
		input_nibble_pt         = 6'h3f;
		port_abc_in             = 24'h123456;
		cyc(2);
		input_nibble_pt = 6'h00;
		port_abc_in     = 24'habcdef;
		cyc(2);
		check(logic_input_bus, 24'h123456);
		input_nibble_pt = 6'h01;
		cyc(2);
		check(logic_input_bus, 24'h12345f);
		input_nibble_pt = 6'h00;
		$display("test input cells done");
	endtask : t_inputs

	// chip selects and term allocation
	task automatic t_misc();
		logic [47:0] exp_b;
		for (int i = 0; i < 2; i++)
		begin
			{ecs_pt, ecs_active_low, ecs_oe_pt, ecs_dir} = ecs_cases[i];
			cyc(2);
			check(external_select_outputs, ecs_exp[i][15:8]);
			check(external_select_oe_n, ecs_exp[i][7:0]);
		end
		cell_pt_need[3:0]   = 4'ha;
		cell_pt_need[35:32] = 4'h9;
		cell_pt_need[51:48] = 4'ha;
		exp_b               = '0;
		exp_b[2:0]          = 3'h6;
		exp_b[26:24]        = 3'h5;
		exp_b[38:36]        = 3'h6;
		cyc(1);
		check(cell_borrowed, exp_b);
		check(cell_expanded, 16'h0001);
		// only cell 15 leaves terms over: first claimant takes all four
		for (int c = 0; c < 16; c++)
			cell_pt_need[4*c +: 4] = (c < 2) ? 4'h9 : (c < 8) ? 4'h3 : (c < 15) ? 4'h4 : 4'h0;
		exp_b      = '0;
		exp_b[2:0] = 3'h4;
		cyc(1);
		check(cell_borrowed, exp_b);
		check(cell_expanded, 16'h0003);
		// term clock: spilled cell 1 takes last cycle's sum, plain cell 3 the current one
		cell_sum_pt = 16'h000a;
		cell_clk_pt = 16'h000a;
		cyc(2);
		check(cell_feedback, 16'h3c9c);
		cell_clk_pt = 16'h0000;
		$display("test selects and allocation done");
	endtask : t_misc

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		errors    = 0;
		tests_run = 0;
		{address_strobe, macrocell_clock_input, slave_read_pt, port_a_data_out} = '0;
		{ecs_pt, ecs_active_low, ecs_oe_pt, ecs_dir, cell_sum_pt, cell_clk_pt} = '0;
		{cell_clk_sel_ext, cell_preset_pt, cell_clear_pt, cell_oe_pt, port_dir} = '0;
		{cell_has_oe_eq, port_abc_in, input_cell_mode, cell_pt_need} = '0;
		{input_nibble_sel_strobe, input_nibble_pt} = '0;
		cell_is_output = 16'hffff;
		rst_n          = 1'b0;
		cyc(12);
		rst_n = 1'b1;
		t_host();
		t_cells();
		t_pins();
		t_inputs();
		t_misc();
		tally_and_finish();
	end

	// the whole run takes about 1.2 microseconds; a hang is cut well past that
	initial
	begin
		#50000;
		errors++;
		tally_and_finish();
	end
endmodule : test_pld_macrocell_host_access
`default_nettype wire
